// >>> dv/testbench.sv
// Self-checking bench for the information flag bank.
// Assumes the line model on channel 0; other line inputs idle.
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, rstn = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
  logic [1:0] bus_chan = 2'h0;
  logic [7:0] bus_addr = 8'h00, bus_wdata = 8'h00, bus_rdata;
  logic [3:0] resync_done = 4'h0, rx_store_overflow = 4'h0, rx_store_underflow = 4'h0, tx_store_overflow = 4'h0;
  logic [3:0] tx_store_underflow = 4'h0, fbit_valid = 4'h0, fbit_err = 4'h0, ais_ci_seen = 4'h0;
  logic [31:0] resync_align = 32'h0;
  int n_errors = 0;
  int cmp_count = 0;
  wire logic lclk, lp, ln;
  wire logic [3:0] rx_line_clk = {3'h0, lclk}, rx_positive_rail = {3'h0, lp}, rx_negative_rail = {3'h0, ln};
  tri_info_bank dut (.ref_clk, .rstn, .bus_chan, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
    .rx_line_clk, .rx_positive_rail, .rx_negative_rail, .resync_done, .resync_align, .rx_store_overflow,
    .rx_store_underflow, .tx_store_overflow, .tx_store_underflow, .fbit_valid, .fbit_err, .ais_ci_seen);
  tri_line_model u_line (.line_clk(lclk), .pos_rail(lp), .neg_rail(ln));
  always #2 ref_clk = ~ref_clk;
  task automatic wr(input logic [1:0] c, input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    {resync_done, rx_store_overflow, rx_store_underflow, tx_store_overflow} = 16'h0;
    {tx_store_underflow, fbit_valid, fbit_err, ais_ci_seen} = 16'h0;
    {bus_wr, bus_chan, bus_addr, bus_wdata} = {1'b1, c, a, d};
    @(negedge ref_clk);
    bus_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] c, input logic [7:0] a, output logic [7:0] v);
    @(negedge ref_clk);
    {bus_rd, bus_chan, bus_addr} = {1'b1, c, a};
    @(negedge ref_clk);
    bus_rd = 1'b0;
    v = bus_rdata;
  endtask : rd
  // Write-back is needed: events arrive unrelated to the port access
  task automatic poll(input logic [1:0] c, input logic [7:0] a, input logic [7:0] m, output logic [7:0] v);
    wr(c, a, m);
    rd(c, a, v);
    wr(c, a, v & m);
  endtask : poll
  task automatic set_ev(input int k, input logic [1:0] c);
    @(negedge ref_clk);
    case (k)
      0: {fbit_valid[c], fbit_err[c]} = 2'b11;
      1: rx_store_overflow[c] = 1'b1;
      2: rx_store_underflow[c] = 1'b1;
      3: tx_store_underflow[c] = 1'b1;
      4: tx_store_overflow[c] = 1'b1;
      5: ais_ci_seen[c] = 1'b1;
      default: {resync_done[c], resync_align[c*8+:8]} = 9'h15a;
    endcase
  endtask : set_ev
  task automatic t_reset;
    logic [7:0] ad[4] = '{8'h22, 8'h31, 8'h10, 8'h20};
    logic [7:0] v;
    for (int k = 0; k < 4; k++) begin
      wr(2'h0, ad[k], 8'hff);
      rd(2'h0, ad[k], v);
      `CHK(v, 8'h00)
    end
  endtask : t_reset
  task automatic t_events;
    logic [1:0] ch[8] = '{2'h0, 2'h2, 2'h2, 2'h1, 2'h1, 2'h3, 2'h1, 2'h1};
    logic [7:0] ad[8] = '{8'h22, 8'h22, 8'h22, 8'h31, 8'h31, 8'h10, 8'h22, 8'h22};
    logic [7:0] m[8] = '{8'hff, 8'hff, 8'hff, 8'h18, 8'h18, 8'h01, 8'h80, 8'h80};
    logic [7:0] e[8] = '{8'h01, 8'h10, 8'h08, 8'h18, 8'h08, 8'h01, 8'h80, 8'h00};
    logic [7:0] v;
    for (int k = 0; k < 8; k++) begin
      set_ev(k, ch[k]);
      poll(ch[k], ad[k], m[k], v);
      `CHK(v, e[k])
      poll(ch[k], ad[k], m[k], v);
      `CHK(v, 8'h00)
    end
  endtask : t_events
  task automatic t_mask;
    logic [7:0] v1, v;
    set_ev(1, 2'h0);
    wr(2'h0, 8'h22, 8'hff);
    rd(2'h0, 8'h22, v1);
    wr(2'h0, 8'h22, 8'h00);
    rd(2'h0, 8'h22, v);
    `CHK(v1, 8'h10)
    `CHK(v, v1)
    set_ev(0, 2'h0);
    wr(2'h0, 8'h22, 8'h01);
    rd(2'h0, 8'h22, v);
    `CHK(v, 8'h11)
    // Second bad framing bit in a row on channel 0; full poll also empties the copy
    poll(2'h0, 8'h22, 8'hff, v);
    `CHK(v, 8'h04)
  endtask : t_mask
  task automatic t_severe;
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      @(negedge ref_clk);
      {fbit_valid[2], fbit_err[2]} = {1'b1, i == 0 || i > 5};
      @(negedge ref_clk);
      fbit_valid[2] = 1'b0;
      if (i == 6) begin
        poll(2'h2, 8'h22, 8'h05, v);
        `CHK(v, 8'h01)
      end
    end
    poll(2'h2, 8'h22, 8'h05, v);
    `CHK(v, 8'h05)
  endtask : t_severe
  // Frames carry four marks either side so the line flops fill and drain
  task automatic t_line;
    logic [31:0] pp[4] = '{32'h2805, 32'h5005, 32'h500005, 32'h5505};
    logic [31:0] nn[4] = '{32'h500a, 32'ha00a, 32'ha0000a, 32'ha88a};
    int len[4] = '{15, 16, 24, 16};
    logic [7:0] e[4] = '{8'h00, 8'h40, 8'h60, 8'h02};
    logic [7:0] v;
    for (int k = 0; k < 4; k++) begin
      u_line.send(pp[k], nn[k], len[k]);
      repeat (20) @(negedge ref_clk);
      poll(2'h0, 8'h22, 8'h62, v);
      `CHK(v, e[k])
    end
    poll(2'h1, 8'h22, 8'h62, v);
    `CHK(v, 8'h00)
    poll(2'h0, 8'h10, 8'h10, v);
    repeat (520) @(negedge ref_clk);
    poll(2'h0, 8'h10, 8'h10, v);
    `CHK(v, 8'h10)
    poll(2'h0, 8'h10, 8'h10, v);
    `CHK(v, 8'h00)
  endtask : t_line
  task automatic final_report;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (2) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (3) @(negedge ref_clk);
    t_reset();
    t_events();
    t_mask();
    t_severe();
    t_line();
    final_report();
  end
  initial begin
    #100000;
    n_errors++;
    final_report();
  end
endmodule : testbench

// >>> dv/tri_info_monitor.sv
// Port assertions for the information flag bank.
// Assumes it is bound to tri_info_bank and sees only its ports.
module tri_info_monitor (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Parallel port
  input wire logic [1:0] bus_chan,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  // Framer events
  input wire logic [3:0] rx_store_overflow,
  input wire logic [3:0] tx_store_underflow,
  input wire logic [3:0] fbit_valid,
  input wire logic [3:0] fbit_err,
  input wire logic [3:0] ais_ci_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire logic at1 = bus_addr == 8'h22, at2 = bus_addr == 8'h31, at3 = bus_addr == 8'h10;
  wire logic c0 = bus_chan == 2'h0, c1 = bus_chan == 2'h1, c2 = bus_chan == 2'h2, c3 = bus_chan == 2'h3;
  a_rdata_hold: assert property (!bus_rd |=> $stable(bus_rdata))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (bus_rd && !(at1 || at2 || at3) |=> bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_three_unused: assert property (bus_rd && at3 |=> (bus_rdata & 8'hee) == 8'h00)
    else $error("unused bits of register three not zero");
  // Port accesses leave one idle cycle between them, hence the two-cycle steps
  a_mask_keep: assert property (bus_rd && at1 && c0 ##2 bus_wr && at1 && c0 && bus_wdata == 8'h00
    ##2 bus_rd && at1 && c0 |=> bus_rdata == $past(bus_rdata, 4)) else $error("zero mask changed copy");
  a_fbe_flag: assert property (fbit_valid[0] && fbit_err[0] ##1 bus_wr && at1 && c0 && bus_wdata[0]
    ##2 bus_rd && at1 && c0 |=> bus_rdata[0]) else $error("framing bit error not reported");
  a_rx_full: assert property (rx_store_overflow[2] ##1 bus_wr && at1 && c2 && bus_wdata[4]
    ##2 bus_rd && at1 && c2 |=> bus_rdata[4]) else $error("receive store full not reported");
  a_tx_slip: assert property (tx_store_underflow[1] ##1 bus_wr && at2 && c1 && bus_wdata[4:3] == 2'b11
    ##2 bus_rd && at2 && c1 |=> bus_rdata[4:3] == 2'b11) else $error("transmit underflow not reported");
  a_ais_flag: assert property (ais_ci_seen[3] ##1 bus_wr && at3 && c3 && bus_wdata[0]
    ##2 bus_rd && at3 && c3 |=> bus_rdata[0]) else $error("AIS-CI not reported");
endmodule : tri_info_monitor

bind tri_info_bank tri_info_monitor u_mon (.ref_clk, .rstn, .bus_chan, .bus_addr, .bus_wdata, .bus_wr,
  .bus_rd, .bus_rdata, .rx_store_overflow, .tx_store_underflow, .fbit_valid, .fbit_err, .ais_ci_seen);

// >>> dv/tri_line_model.sv
// Line-side stand-in for one channel: rails plus a 125 ns line clock.
// Assumes the bench calls send; bit 0 goes out first.
module tri_line_model (
  // Line clock and rails
  output logic line_clk,
  output logic pos_rail,
  output logic neg_rail
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    line_clk = 1'b0;
    pos_rail = 1'b0;
    neg_rail = 1'b0;
  end
  // Clock runs only inside a frame, so clock loss can be provoked
  task automatic send(input logic [31:0] p, input logic [31:0] n, input int len);
    for (int i = 0; i < len; i++) begin
      pos_rail = p[i];
      neg_rail = n[i];
      #62.5 line_clk = 1'b1;
      #62.5 line_clk = 1'b0;
    end
    // Released rails show no stale copy of the last bit
    pos_rail = ~pos_rail;
    neg_rail = ~neg_rail;
  endtask : send
endmodule : tri_line_model

// >>> verilog/tri_info_bank.sv
// Latched receive/transmit information flags for every framer channel.
// Assumes framer event inputs are single-cycle pulses on ref_clk and that
// the parallel port strobes are synchronous to ref_clk.

// Operation
// - Flag alignment change after each differing resync
// - Flag runs of eight or more zeros
// - Flag runs of sixteen or more zeros
// - Flag receive store overflow, frame dropped
// - Flag receive store underflow, frame replayed
// - Flag two bad of six framing bits
// - Flag code word seen, 000VB0VB pattern only
// - Flag each erroneous framing bit
// - Flag transmit store underflow
// - Flag transmit store replay or drop
// - Flag receive clock idle two microseconds
// - Flag AIS-CI pattern recognised
// - Unused third-register bits read as zero
// - Flags latch until a mask write captures them, then clear
// - Write refreshes copy only where one
// - Zero mask bits keep prior copy
module tri_info_bank (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Parallel port
  input wire logic [tri_pkg::CH_W-1:0] bus_chan,
  input wire logic [tri_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [tri_pkg::DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [tri_pkg::DATA_W-1:0] bus_rdata,
  // Line side, one bit per channel
  input wire logic [tri_pkg::NUM_CH-1:0] rx_line_clk,
  input wire logic [tri_pkg::NUM_CH-1:0] rx_positive_rail,
  input wire logic [tri_pkg::NUM_CH-1:0] rx_negative_rail,
  // Framer events, one bit per channel; resync_align carries eight bits per channel
  input wire logic [tri_pkg::NUM_CH-1:0] resync_done,
  input wire logic [tri_pkg::NUM_CH*tri_pkg::ALIGN_W-1:0] resync_align,
  input wire logic [tri_pkg::NUM_CH-1:0] rx_store_overflow,
  input wire logic [tri_pkg::NUM_CH-1:0] rx_store_underflow,
  input wire logic [tri_pkg::NUM_CH-1:0] tx_store_overflow,
  input wire logic [tri_pkg::NUM_CH-1:0] tx_store_underflow,
  input wire logic [tri_pkg::NUM_CH-1:0] fbit_valid,
  input wire logic [tri_pkg::NUM_CH-1:0] fbit_err,
  input wire logic [tri_pkg::NUM_CH-1:0] ais_ci_seen
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_q;
  logic srstn;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) rst_q <= 2'h0;
    else rst_q <= {rst_q[0], 1'b1};
  end
  assign srstn = rst_q[1];

  // ----------------------------------------------------------------
  // Port decode
  // ----------------------------------------------------------------
  wire hit_one = bus_addr == tri_pkg::ADDR_INFO_ONE;
  wire hit_two = bus_addr == tri_pkg::ADDR_INFO_TWO;
  wire hit_three = bus_addr == tri_pkg::ADDR_INFO_THREE;
  wire [7:0] wmask_one = bus_wdata & tri_pkg::MASK_ONE;
  wire [7:0] wmask_two = bus_wdata & tri_pkg::MASK_TWO;
  wire [7:0] wmask_three = bus_wdata & tri_pkg::MASK_THREE;

  logic [tri_pkg::NUM_CH*8-1:0] copy_one_flat, copy_two_flat, copy_three_flat;

  function automatic logic [2:0] count_ones(input logic [5:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int k = 0; k < 6; k++) n = n + {2'h0, v[k]};
    return n;
  endfunction : count_ones

  // ----------------------------------------------------------------
  // Per-channel flag logic
  // ----------------------------------------------------------------
  for (genvar ch = 0; ch < tri_pkg::NUM_CH; ch++) begin : g_ch
    logic z8_tgl, z16_tgl, cw_tgl;
    logic [2:0] z8_sync_q, z16_sync_q, cw_sync_q;
    logic [2:0] lclk_sync_q;
    logic [tri_pkg::CLOCK_LOSS_W-1:0] idle_q;
    logic [tri_pkg::SEVERE_WINDOW-2:0] fhist_q;
    logic [tri_pkg::ALIGN_W-1:0] align_q;
    logic [7:0] lat_one_q, lat_two_q, lat_three_q;
    logic [7:0] copy_one_q, copy_two_q, copy_three_q;
    logic [7:0] ev_one, ev_two, ev_three;
    logic [7:0] clr_one, clr_two, clr_three;

    // Own detector per channel, no shared state
    tri_line_detect u_line (
      .line_clk(rx_line_clk[ch]),
      .rstn(rstn),
      .rx_positive_rail(rx_positive_rail[ch]),
      .rx_negative_rail(rx_negative_rail[ch]),
      .eight_zero_tgl(z8_tgl),
      .sixteen_zero_tgl(z16_tgl),
      .code_word_tgl(cw_tgl)
    );

    // Toggle crossings; third stage only feeds the edge compare
    always_ff @(posedge ref_clk or negedge srstn) begin
      if (!srstn) begin
        z8_sync_q <= 3'h0;
        z16_sync_q <= 3'h0;
        cw_sync_q <= 3'h0;
        lclk_sync_q <= 3'h0;
      end else begin
        z8_sync_q <= {z8_sync_q[1:0], z8_tgl};
        z16_sync_q <= {z16_sync_q[1:0], z16_tgl};
        cw_sync_q <= {cw_sync_q[1:0], cw_tgl};
        lclk_sync_q <= {lclk_sync_q[1:0], rx_line_clk[ch]};
      end
    end

    wire z8_ev = z8_sync_q[2] ^ z8_sync_q[1];
    wire z16_ev = z16_sync_q[2] ^ z16_sync_q[1];
    wire cw_ev = cw_sync_q[2] ^ cw_sync_q[1];

    // Receive clock watchdog; counter parks at the limit
    wire lclk_edge = lclk_sync_q[2] ^ lclk_sync_q[1];
    wire idle_full = idle_q == tri_pkg::CLOCK_LOSS_W'(tri_pkg::CLOCK_LOSS_CYC);
    wire clk_loss_ev = !lclk_edge &&
      idle_q == tri_pkg::CLOCK_LOSS_W'(tri_pkg::CLOCK_LOSS_CYC - 1);

    // Framing bit history and severe error window
    wire fbe_ev = fbit_valid[ch] && fbit_err[ch];
    wire [2:0] bad_in_win = count_ones({fhist_q, fbit_err[ch]});
    wire severe_ev = fbit_valid[ch] && bad_in_win >= 3'(tri_pkg::SEVERE_ERRORS);

    // Alignment compare against the previous resync result
    wire [tri_pkg::ALIGN_W-1:0] new_align = resync_align[ch*tri_pkg::ALIGN_W +: tri_pkg::ALIGN_W];
    wire align_ev = resync_done[ch] && new_align != align_q;

    always_ff @(posedge ref_clk or negedge srstn) begin
      if (!srstn) begin
        idle_q <= '0;
        fhist_q <= '0;
        align_q <= '0;
      end else begin
        if (lclk_edge) idle_q <= '0;
        else if (!idle_full) idle_q <= idle_q + 1'b1;
        if (fbit_valid[ch]) fhist_q <= {fhist_q[tri_pkg::SEVERE_WINDOW-3:0], fbit_err[ch]};
        if (resync_done[ch]) align_q <= new_align;
      end
    end

    always_comb begin
      ev_one = 8'h00;
      ev_one[tri_pkg::BIT_ALIGN_CHANGE] = align_ev;
      ev_one[tri_pkg::BIT_EIGHT_ZERO] = z8_ev;
      ev_one[tri_pkg::BIT_SIXTEEN_ZERO] = z16_ev;
      ev_one[tri_pkg::BIT_RX_FULL] = rx_store_overflow[ch];
      ev_one[tri_pkg::BIT_RX_EMPTY] = rx_store_underflow[ch];
      ev_one[tri_pkg::BIT_SEVERE] = severe_ev;
      ev_one[tri_pkg::BIT_CODE_WORD] = cw_ev;
      ev_one[tri_pkg::BIT_FRAME_BIT] = fbe_ev;
      ev_two = 8'h00;
      ev_two[tri_pkg::BIT_TX_EMPTY] = tx_store_underflow[ch];
      ev_two[tri_pkg::BIT_TX_SLIP] = tx_store_underflow[ch] | tx_store_overflow[ch];
      ev_three = 8'h00;
      ev_three[tri_pkg::BIT_CLOCK_LOSS] = clk_loss_ev;
      ev_three[tri_pkg::BIT_AIS_CI] = ais_ci_seen[ch];
    end

    // A mask write captures the selected flags and clears them
    wire ch_wr = bus_wr && bus_chan == tri_pkg::CH_W'(ch);
    assign clr_one = (ch_wr && hit_one) ? wmask_one : 8'h00;
    assign clr_two = (ch_wr && hit_two) ? wmask_two : 8'h00;
    assign clr_three = (ch_wr && hit_three) ? wmask_three : 8'h00;

    // Set wins over clear, so an event in the capture cycle stays latched
    always_ff @(posedge ref_clk or negedge srstn) begin
      if (!srstn) begin
        lat_one_q <= tri_pkg::INFO_RESET;
        lat_two_q <= tri_pkg::INFO_RESET;
        lat_three_q <= tri_pkg::INFO_RESET;
      end else begin
        lat_one_q <= (lat_one_q & ~clr_one) | ev_one;
        lat_two_q <= (lat_two_q & ~clr_two) | ev_two;
        lat_three_q <= (lat_three_q & ~clr_three) | ev_three;
      end
    end

    always_ff @(posedge ref_clk or negedge srstn) begin
      if (!srstn) begin
        copy_one_q <= tri_pkg::INFO_RESET;
        copy_two_q <= tri_pkg::INFO_RESET;
        copy_three_q <= tri_pkg::INFO_RESET;
      end else begin
        copy_one_q <= (copy_one_q & ~clr_one) | (lat_one_q & clr_one);
        copy_two_q <= (copy_two_q & ~clr_two) | (lat_two_q & clr_two);
        copy_three_q <= (copy_three_q & ~clr_three) | (lat_three_q & clr_three);
      end
    end

    assign copy_one_flat[ch*8 +: 8] = copy_one_q;
    assign copy_two_flat[ch*8 +: 8] = copy_two_q;
    // Unused positions read as zero
    assign copy_three_flat[ch*8 +: 8] = copy_three_q & tri_pkg::MASK_THREE;
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [tri_pkg::DATA_W-1:0] rdata_q;
  wire [7:0] rsel_one = copy_one_flat[bus_chan*8 +: 8];
  wire [7:0] rsel_two = copy_two_flat[bus_chan*8 +: 8];
  wire [7:0] rsel_three = copy_three_flat[bus_chan*8 +: 8];
  // Unmapped offsets answer zero
  wire [7:0] rsel = hit_one ? rsel_one : hit_two ? rsel_two : hit_three ? rsel_three : 8'h00;

  // The copy read holds what the previous mask write captured
  always_ff @(posedge ref_clk or negedge srstn) begin
    if (!srstn) rdata_q <= tri_pkg::RDATA_RESET;
    else if (bus_rd) rdata_q <= rsel;
  end
  assign bus_rdata = rdata_q;

endmodule : tri_info_bank

// >>> verilog/tri_line_detect.sv
// Line-clock side detectors for one channel: zero runs and code words.
// Assumes rails change on the line clock; events leave as toggles.
module tri_line_detect (
  // Line clock and reset
  input wire logic line_clk,
  input wire logic rstn,
  // Receive rails
  input wire logic rx_positive_rail,
  input wire logic rx_negative_rail,
  // Event toggles, one flip per event
  output logic eight_zero_tgl,
  output logic sixteen_zero_tgl,
  output logic code_word_tgl
);

  // ----------------------------------------------------------------
  // Reset release and rail sampling
  // ----------------------------------------------------------------
  logic [1:0] lrst_q;
  logic pos_s1_q, pos_s2_q, neg_s1_q, neg_s2_q;
  logic lrstn;

  always_ff @(posedge line_clk or negedge rstn) begin
    if (!rstn) lrst_q <= 2'h0;
    else lrst_q <= {lrst_q[0], 1'b1};
  end
  assign lrstn = lrst_q[1];

  always_ff @(posedge line_clk or negedge lrstn) begin
    if (!lrstn) begin
      pos_s1_q <= 1'b0;
      pos_s2_q <= 1'b0;
      neg_s1_q <= 1'b0;
      neg_s2_q <= 1'b0;
    end else begin
      pos_s1_q <= rx_positive_rail;
      pos_s2_q <= pos_s1_q;
      neg_s1_q <= rx_negative_rail;
      neg_s2_q <= neg_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Zero run counter
  // ----------------------------------------------------------------
  logic [tri_pkg::ZERO_CNT_W-1:0] zcnt_q, zcnt_d;
  wire zero_bit = !pos_s2_q && !neg_s2_q;
  // Counter saturates so one long run gives one event each
  wire zero_cap = zcnt_q == tri_pkg::ZERO_CNT_W'(tri_pkg::ZERO_RUN_LONG);
  wire z8_ev = zero_bit && zcnt_q == tri_pkg::ZERO_CNT_W'(tri_pkg::ZERO_RUN_SHORT - 1);
  wire z16_ev = zero_bit && zcnt_q == tri_pkg::ZERO_CNT_W'(tri_pkg::ZERO_RUN_LONG - 1);

  assign zcnt_d = !zero_bit ? '0 : (zero_cap ? zcnt_q : zcnt_q + 1'b1);

  // ----------------------------------------------------------------
  // Code word window: 000VB0VB, oldest bit at position 7
  // ----------------------------------------------------------------
  logic [7:0] pwin_q, nwin_q;
  logic pol_q;
  wire [7:0] same = pol_q ? pwin_q : nwin_q;
  wire [7:0] opp = pol_q ? nwin_q : pwin_q;
  wire [7:0] any_mark = pwin_q | nwin_q;
  wire cw_zeros = !any_mark[7] && !any_mark[6] && !any_mark[5] && !any_mark[2];
  wire cw_ev = cw_zeros && same[4] && opp[3] && opp[1] && same[0];

  always_ff @(posedge line_clk or negedge lrstn) begin
    if (!lrstn) begin
      zcnt_q <= '0;
      pwin_q <= 8'h00;
      nwin_q <= 8'h00;
      pol_q <= 1'b0;
    end else begin
      zcnt_q <= zcnt_d;
      pwin_q <= {pwin_q[6:0], pos_s2_q};
      nwin_q <= {nwin_q[6:0], neg_s2_q};
      // Polarity of the last mark ahead of the window
      if (pwin_q[7]) pol_q <= 1'b1;
      else if (nwin_q[7]) pol_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Event toggles
  // ----------------------------------------------------------------
  always_ff @(posedge line_clk or negedge lrstn) begin
    if (!lrstn) begin
      eight_zero_tgl <= 1'b0;
      sixteen_zero_tgl <= 1'b0;
      code_word_tgl <= 1'b0;
    end else begin
      eight_zero_tgl <= eight_zero_tgl ^ z8_ev;
      sixteen_zero_tgl <= sixteen_zero_tgl ^ z16_ev;
      code_word_tgl <= code_word_tgl ^ cw_ev;
    end
  end

endmodule : tri_line_detect

// >>> verilog/tri_pkg.sv
// Constants for the per-channel receive/transmit information flag bank.
// Assumes a 250 MHz register clock and byte-wide parallel port access.
package tri_pkg;

  // ----------------------------------------------------------------
  // Structure
  // ----------------------------------------------------------------
  localparam int NUM_CH = 4;
  localparam int CH_W = 2;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int ALIGN_W = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_INFO_THREE = 8'h10;
  localparam logic [7:0] ADDR_INFO_ONE = 8'h22;
  localparam logic [7:0] ADDR_INFO_TWO = 8'h31;

  // ----------------------------------------------------------------
  // Field positions, information register one
  // ----------------------------------------------------------------
  localparam int BIT_ALIGN_CHANGE = 7;
  localparam int BIT_EIGHT_ZERO = 6;
  localparam int BIT_SIXTEEN_ZERO = 5;
  localparam int BIT_RX_FULL = 4;
  localparam int BIT_RX_EMPTY = 3;
  localparam int BIT_SEVERE = 2;
  localparam int BIT_CODE_WORD = 1;
  localparam int BIT_FRAME_BIT = 0;

  // ----------------------------------------------------------------
  // Field positions, registers two and three
  // ----------------------------------------------------------------
  localparam int BIT_TX_EMPTY = 4;
  localparam int BIT_TX_SLIP = 3;
  localparam int BIT_CLOCK_LOSS = 4;
  localparam int BIT_AIS_CI = 0;

  // ----------------------------------------------------------------
  // Implemented bits and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_ONE = 8'hff;
  localparam logic [7:0] MASK_TWO = 8'h18;
  localparam logic [7:0] MASK_THREE = 8'h11;
  localparam logic [7:0] INFO_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Timing and detector counts
  // ----------------------------------------------------------------
  localparam int REF_PERIOD_PS = 4000;
  localparam int CLOCK_LOSS_NS = 2000;
  localparam int CLOCK_LOSS_CYC = (CLOCK_LOSS_NS * 1000 + REF_PERIOD_PS - 1) / REF_PERIOD_PS;
  localparam int CLOCK_LOSS_W = 10;
  localparam int ZERO_RUN_SHORT = 8;
  localparam int ZERO_RUN_LONG = 16;
  localparam int ZERO_CNT_W = 5;
  localparam int SEVERE_WINDOW = 6;
  localparam int SEVERE_ERRORS = 2;

endpackage : tri_pkg
